//--- inc/pcd_pkg.sv
// shared constants and types for the peripheral clock disable block
package pcd_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int NUM_REGS = 7;
    localparam int NUM_PERIPH = 18;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] DIS_BASE_OFFSET = 12'h004;
    localparam logic [ADDR_W-1:0] DIS_LAST_OFFSET = 12'h01c;
    localparam logic [ADDR_W-1:0] KEY_OFFSET = 12'h020;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h024;

    ////////////////////////////////////////////////////////////////////////
    // control and status fields
    localparam int LOCK_BIT = 11;
    localparam int STATUS_OPEN_BIT = 0;
    localparam int STATUS_LOCK_BIT = 1;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic [DATA_W-1:0] DIS_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] KEY_FIRST = 32'haa99_6655;
    localparam logic [DATA_W-1:0] KEY_SECOND = 32'h5566_99aa;

    ////////////////////////////////////////////////////////////////////////
    // disable bit positions within their registers
    localparam int CONVERTER_OFF_BIT = 0;
    localparam int VOLTAGE_REF_OFF_BIT = 12;
    localparam int VOLTAGE_DETECT_OFF_BIT = 20;
    localparam int COMPARATOR1_OFF_BIT = 0;
    localparam int COMPARATOR2_OFF_BIT = 1;
    localparam int LOGIC_CELL1_OFF_BIT = 24;
    localparam int LOGIC_CELL2_OFF_BIT = 25;
    localparam int CAPTURE_UNIT1_OFF_BIT = 8;
    localparam int CAPTURE_UNIT2_OFF_BIT = 9;
    localparam int CAPTURE_UNIT3_OFF_BIT = 10;
    localparam int TIMER1_OFF_BIT = 0;
    localparam int UART1_OFF_BIT = 0;
    localparam int UART2_OFF_BIT = 1;
    localparam int SERIAL_PORT1_OFF_BIT = 8;
    localparam int SERIAL_PORT2_OFF_BIT = 9;
    localparam int CALENDAR_CLOCK_OFF_BIT = 0;
    localparam int REF_CLOCK_OUT_OFF_BIT = 8;
    localparam int CHECKSUM_UNIT_OFF_BIT = 3;

    // implemented bits of disable_reg_1 (index 0) to disable_reg_7 (index 6)
    localparam logic [NUM_REGS-1:0][DATA_W-1:0] DIS_MASK = {
        32'h0000_0008,
        32'h0000_0101,
        32'h0000_0303,
        32'h0000_0001,
        32'h0000_0700,
        32'h0300_0003,
        32'h0010_1001
    };

    // peripheral n: register index and bit position of its disable bit
    localparam int PERIPH_REG [NUM_PERIPH] = '{
        0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 4, 4, 4, 4, 5, 5, 6
    };
    localparam int PERIPH_BIT [NUM_PERIPH] = '{
        CONVERTER_OFF_BIT, VOLTAGE_REF_OFF_BIT, VOLTAGE_DETECT_OFF_BIT,
        COMPARATOR1_OFF_BIT, COMPARATOR2_OFF_BIT, LOGIC_CELL1_OFF_BIT,
        LOGIC_CELL2_OFF_BIT, CAPTURE_UNIT1_OFF_BIT, CAPTURE_UNIT2_OFF_BIT,
        CAPTURE_UNIT3_OFF_BIT, TIMER1_OFF_BIT, UART1_OFF_BIT, UART2_OFF_BIT,
        SERIAL_PORT1_OFF_BIT, SERIAL_PORT2_OFF_BIT, CALENDAR_CLOCK_OFF_BIT,
        REF_CLOCK_OUT_OFF_BIT, CHECKSUM_UNIT_OFF_BIT
    };

    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_HALF = 3'b010,
        KEY_OPEN = 3'b100
    } pcd_key_state_type;

endpackage

//--- sim/tb_top.sv
// self-checking bench for the peripheral clock disable block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
import pcd_pkg::*;

logic clock;
logic rst_b;
logic psel;
logic penable;
logic pwrite;
logic [ADDR_W-1:0] paddr;
logic [DATA_W-1:0] pwdata;
logic [DATA_W-1:0] prdata;
logic pready;
logic pslverr;
logic [NUM_PERIPH-1:0] periph_wr_in;
logic [NUM_PERIPH-1:0] periph_wr_out;
logic [NUM_PERIPH-1:0] periph_rd_valid;
logic [NUM_PERIPH-1:0] periph_disabled;
logic [NUM_PERIPH-1:0] periph_clock;
logic [NUM_PERIPH-1:0] wr_pat;
logic [NUM_PERIPH-1:0] exp_dis;
int error_cnt;
int checks_done;

pcd_peripheral_disable i_dut
(
    .clock(clock),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .periph_wr_in(periph_wr_in),
    .periph_wr_out(periph_wr_out),
    .periph_rd_valid(periph_rd_valid),
    .periph_disabled(periph_disabled),
    .periph_clock(periph_clock)
);

////////////////////////////////////////////////////////////////////////////
initial
begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
end

task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask

task automatic chk(input logic [DATA_W-1:0] got,
    input logic [DATA_W-1:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
endtask

// master holds the request until pready is seen high at a rising edge
task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
    output logic err);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
        n++;
        if (n > 100)
        begin
            error_cnt++;
            $display("BAD %0t bus answer never came", $time);
            wrap_up();
        end
        @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic e);
    logic [DATA_W-1:0] r;
    logic err;
    apb(1'b1, a, d, r, err);
    chk(32'(err), 32'(e), "write error flag");
endtask

task automatic rd_chk(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic e);
    logic [DATA_W-1:0] r;
    logic err;
    apb(1'b0, a, 32'h0, r, err);
    chk(r, d, "read data");
    chk(32'(err), 32'(e), "read error flag");
endtask

task automatic unlock();
    wr(KEY_OFFSET, KEY_FIRST, 1'b0);
    wr(KEY_OFFSET, KEY_SECOND, 1'b0);
endtask

function automatic logic [ADDR_W-1:0] dis_addr(input int i);
    return DIS_BASE_OFFSET + ADDR_W'(4 * i);
endfunction

// write strobes change every call so the gate is seen both ways
task automatic side_chk(input logic [NUM_PERIPH-1:0] dis);
    logic [NUM_PERIPH-1:0] en;
    logic [NUM_PERIPH-1:0] gw;
    wr_pat = {wr_pat[NUM_PERIPH-2:0], ~wr_pat[NUM_PERIPH-1]};
    @(posedge clock);
    periph_wr_in <= wr_pat;
    repeat (3) @(posedge clock);
    #2;
    en = ~dis;
    gw = wr_pat & en;
    chk(32'(periph_disabled), 32'(dis), "disable state");
    chk(32'(periph_rd_valid), 32'(en), "read valid");
    chk(32'(periph_wr_out), 32'(gw), "write gating");
    chk(32'(periph_clock), 32'(en), "gated clock high phase");
endtask

// a gated clock may never be high in the low phase of the clock
always @(negedge clock)
begin
    #2;
    chk(32'(periph_clock), 32'h0, "gated clock low phase");
end

initial
begin
    repeat (50000) @(posedge clock);
    error_cnt++;
    $display("BAD %0t run took too long", $time);
    wrap_up();
end

////////////////////////////////////////////////////////////////////////////
initial
begin
    error_cnt = 0;
    checks_done = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    wr_pat = 18'h0aaaa;
    periph_wr_in = 18'h0aaaa;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(CTRL_OFFSET, 32'h0, 1'b0);
    for (int i = 0; i < NUM_REGS; i++)
        rd_chk(dis_addr(i), DIS_RESET, 1'b0);
    side_chk('0);
    // each peripheral alone, at its own register and bit
    for (int n = 0; n < NUM_PERIPH; n++)
    begin
        exp_dis = '0;
        exp_dis[n] = 1'b1;
        wr(dis_addr(PERIPH_REG[n]), 32'h1 << PERIPH_BIT[n], 1'b0);
        side_chk(exp_dis);
        rd_chk(dis_addr(PERIPH_REG[n]), 32'h1 << PERIPH_BIT[n], 1'b0);
        wr(dis_addr(PERIPH_REG[n]), 32'h0, 1'b0);
    end
    for (int i = 0; i < NUM_REGS; i++)
    begin
        wr(dis_addr(i), 32'hffff_ffff, 1'b0);
        rd_chk(dis_addr(i), DIS_MASK[i], 1'b0);
    end
    side_chk('1);
    // lock needs the key; without it the control write is dropped
    wr(CTRL_OFFSET, 32'h0000_0800, 1'b0);
    rd_chk(CTRL_OFFSET, 32'h0, 1'b0);
    unlock();
    wr(CTRL_OFFSET, 32'h0000_0800, 1'b0);
    rd_chk(CTRL_OFFSET, 32'h0000_0800, 1'b0);
    rd_chk(STATUS_OFFSET, 32'h0000_0002, 1'b0);
    wr(dis_addr(0), 32'h0, 1'b0);
    rd_chk(dis_addr(0), DIS_MASK[0], 1'b0);
    side_chk('1);
    // a stray write between the two keys spoils the sequence
    wr(KEY_OFFSET, KEY_FIRST, 1'b0);
    wr(dis_addr(1), 32'h0, 1'b0);
    wr(KEY_OFFSET, KEY_SECOND, 1'b0);
    wr(CTRL_OFFSET, 32'h0, 1'b0);
    rd_chk(CTRL_OFFSET, 32'h0000_0800, 1'b0);
    unlock();
    wr(CTRL_OFFSET, 32'h0, 1'b0);
    rd_chk(CTRL_OFFSET, 32'h0, 1'b0);
    wr(dis_addr(0), 32'h0, 1'b0);
    rd_chk(dis_addr(0), 32'h0, 1'b0);
    exp_dis = '1;
    exp_dis[2:0] = 3'h0;
    side_chk(exp_dis);
    wr(12'h040, 32'hffff_ffff, 1'b1);
    rd_chk(12'h040, 32'h0, 1'b1);
    wrap_up();
end

endmodule
`default_nettype wire

//--- src/pcd_clock_gate.sv
// glitch free clock gate for one peripheral
`timescale 1ns/10ps
`default_nettype none

module pcd_clock_gate
(
    input wire logic clock,
    input wire logic enable,
    output logic gated_clock
);

    logic enable_latch;

    // enable only moves while the clock is low, so no runt pulse escapes
    always_latch
    begin
        if (!clock)
        begin
            enable_latch <= enable;
        end
    end

    assign gated_clock = clock & enable_latch;

endmodule

`default_nettype wire

//--- src/pcd_peripheral_disable.sv
// peripheral clock disable registers, apb slave and per-peripheral gates
`timescale 1ns/10ps
`default_nettype none

// Operation
// - a set disable bit stops the clock to its peripheral
// - a disabled peripheral ignores register writes and its reads are invalid
// - writing one disables, zero enables; every disable bit resets to zero
// - locked disable registers accept writes on the bus but keep contents
// - bit 11 of the control register is the lock; one blocks writes
// - the lock bit changes only after the unlock key sequence
// - register 1 holds converter, voltage reference and detector bits
// - register 2 holds comparator 1, 2 and logic cell 1, 2 bits
// - register 3 bits 8 to 10 disable capture units 1 to 3
// - register 4 bit 0 is timer 1; register 5 bits 0, 1 are uarts
// - register 5 bits 8 and 9 disable serial ports 1 and 2
// - register 6 holds calendar clock bit 0 and reference output bit 8
// - register 7 bit 3 disables the checksum unit
module pcd_peripheral_disable
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcd_pkg::ADDR_W-1:0] paddr,
    input wire logic [pcd_pkg::DATA_W-1:0] pwdata,
    output logic [pcd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pcd_pkg::NUM_PERIPH-1:0] periph_wr_in,
    output logic [pcd_pkg::NUM_PERIPH-1:0] periph_wr_out,
    output logic [pcd_pkg::NUM_PERIPH-1:0] periph_rd_valid,
    output logic [pcd_pkg::NUM_PERIPH-1:0] periph_disabled,
    output logic [pcd_pkg::NUM_PERIPH-1:0] periph_clock
);
    import pcd_pkg::*;

    typedef struct packed {
        logic lock;
        logic [NUM_REGS-1:0][DATA_W-1:0] dis;
        pcd_key_state_type key;
        logic [DATA_W-1:0] rdata;
    } pcd_state_type;

    pcd_state_type cur;
    pcd_state_type next_cur;
    logic rst_meta;
    logic rst_sync;

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic setup;
    logic access;
    logic wr;
    logic sel_ctrl;
    logic sel_dis;
    logic sel_key;
    logic sel_status;
    logic mapped;
    logic [ADDR_W-1:0] dis_delta;
    logic [2:0] dis_idx;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign sel_ctrl = (paddr == CTRL_OFFSET);
    assign sel_key = (paddr == KEY_OFFSET);
    assign sel_status = (paddr == STATUS_OFFSET);
    assign dis_delta = paddr - DIS_BASE_OFFSET;
    assign dis_idx = dis_delta[4:2];
    assign sel_dis = (paddr >= DIS_BASE_OFFSET) &&
        (paddr <= DIS_LAST_OFFSET) && (paddr[1:0] == 2'b00);
    assign mapped = sel_ctrl | sel_dis | sel_key | sel_status;

    // every access finishes in one access cycle, no wait states
    assign pready = access;
    assign pslverr = access & ~mapped;
    assign prdata = cur.rdata;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic [DATA_W-1:0] read_word;
        read_word = '0;
        next_cur = cur;

        // read data is captured in the setup cycle so it leaves a flop
        if (sel_ctrl)
        begin
            read_word[LOCK_BIT] = cur.lock;
        end
        else if (sel_dis)
        begin
            read_word = cur.dis[dis_idx];
        end
        else if (sel_status)
        begin
            read_word[STATUS_OPEN_BIT] = (cur.key == KEY_OPEN);
            read_word[STATUS_LOCK_BIT] = cur.lock;
        end
        if (setup && !pwrite)
        begin
            next_cur.rdata = read_word;
        end

        // unlock key machine; any unrelated write closes the window
        if (wr)
        begin
            case (cur.key)
                KEY_IDLE:
                begin
                    if (sel_key && pwdata == KEY_FIRST)
                    begin
                        next_cur.key = KEY_HALF;
                    end
                end
                KEY_HALF:
                begin
                    if (sel_key && pwdata == KEY_SECOND)
                    begin
                        next_cur.key = KEY_OPEN;
                    end
                    else if (sel_key && pwdata == KEY_FIRST)
                    begin
                        next_cur.key = KEY_HALF;
                    end
                    else
                    begin
                        next_cur.key = KEY_IDLE;
                    end
                end
                KEY_OPEN:
                begin
                    // one write of the control register per unlock
                    if (sel_ctrl)
                    begin
                        next_cur.lock = pwdata[LOCK_BIT];
                    end
                    next_cur.key = KEY_IDLE;
                end
                default:
                begin
                    next_cur.key = KEY_IDLE;
                end
            endcase
        end

        // locked writes complete normally but store nothing
        if (wr && sel_dis && !cur.lock)
        begin
            next_cur.dis[dis_idx] = pwdata & DIS_MASK[dis_idx];
        end
    end

    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            cur.lock <= LOCK_RESET;
            cur.dis <= {NUM_REGS{DIS_RESET}};
            cur.key <= KEY_IDLE;
            cur.rdata <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-peripheral gating
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++)
        begin : g_periph
            assign periph_disabled[gi] =
                cur.dis[PERIPH_REG[gi]][PERIPH_BIT[gi]];
            // a disabled peripheral sees no writes and flags reads invalid
            assign periph_wr_out[gi] =
                periph_wr_in[gi] & ~periph_disabled[gi];
            assign periph_rd_valid[gi] = ~periph_disabled[gi];

            pcd_clock_gate u_gate
            (
                .clock(clock),
                .enable(~periph_disabled[gi]),
                .gated_clock(periph_clock[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync);

    sequence key_first_s;
        wr && sel_key && pwdata == KEY_FIRST && cur.key == KEY_IDLE;
    endsequence

    sequence key_second_s;
        wr && sel_key && pwdata == KEY_SECOND;
    endsequence

    sequence dis_write_s;
        wr && sel_dis;
    endsequence

    locked_write_held_a: assert property (
        dis_write_s and cur.lock |=> $stable(cur.dis))
        else $error("locked disable register changed");

    open_write_stored_a: assert property (
        dis_write_s and !cur.lock |=>
        cur.dis[$past(dis_idx)] == ($past(pwdata) & DIS_MASK[$past(dis_idx)]))
        else $error("unlocked disable write not stored");

    locked_no_error_a: assert property (
        dis_write_s and cur.lock |-> pready && !pslverr)
        else $error("locked write not completed normally");

    lock_needs_key_a: assert property (
        $changed(cur.lock) |->
        $past(cur.key) == KEY_OPEN && $past(wr && sel_ctrl))
        else $error("lock changed without unlock");

    key_half_a: assert property (
        key_first_s |=> cur.key == KEY_HALF)
        else $error("first key did not arm the unlock");

    key_opens_a: assert property (
        key_second_s and cur.key == KEY_HALF |=> cur.key == KEY_OPEN)
        else $error("key sequence did not open");

    lock_bit_read_a: assert property (
        setup && !pwrite && sel_ctrl |=>
        prdata[LOCK_BIT] == $past(cur.lock) && prdata[10:0] == 11'h000)
        else $error("lock bit read wrong");

    reserved_zero_a: assert property (
        (cur.dis[0] & ~DIS_MASK[0]) == '0 &&
        (cur.dis[1] & ~DIS_MASK[1]) == '0 &&
        (cur.dis[2] & ~DIS_MASK[2]) == '0 &&
        (cur.dis[3] & ~DIS_MASK[3]) == '0 &&
        (cur.dis[4] & ~DIS_MASK[4]) == '0 &&
        (cur.dis[5] & ~DIS_MASK[5]) == '0 &&
        (cur.dis[6] & ~DIS_MASK[6]) == '0)
        else $error("unimplemented disable bit set");

    timer_bit_map_a: assert property (
        periph_disabled[10] == cur.dis[3][0] &&
        periph_disabled[17] == cur.dis[6][3])
        else $error("disable bit mapping wrong");

    disabled_no_write_a: assert property (
        (periph_wr_out & periph_disabled) == '0 &&
        periph_rd_valid == ~periph_disabled)
        else $error("disabled peripheral still written");

    reset_clear_a: assert property (
        $rose(rst_sync) |-> (periph_disabled == '0) [*2])
        else $error("disable bits not clear after reset");

    unmapped_err_a: assert property (
        access && !mapped |-> pslverr ##1 (prdata == $past(prdata) ||
        $past(setup)))
        else $error("unmapped access without error");

endmodule

`default_nettype wire
